// [hdl/ssrp_pkg.sv]
// shared constants and functions for the sensor setup, reset and pll register bank
package ssrp_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FIELD_W = 4;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_IDENT       = 9'h000;
  localparam logic [ADDR_W-1:0] ADDR_RSVD_ONE    = 9'h001;
  localparam logic [ADDR_W-1:0] ADDR_VARIANT     = 9'h002;
  localparam logic [ADDR_W-1:0] ADDR_PLL_RST     = 9'h008;
  localparam logic [ADDR_W-1:0] ADDR_CGEN_RST    = 9'h009;
  localparam logic [ADDR_W-1:0] ADDR_ANALOG_RST  = 9'h00a;
  localparam logic [ADDR_W-1:0] ADDR_PLL_PWR     = 9'h010;
  localparam logic [ADDR_W-1:0] ADDR_PLL_RSVD    = 9'h011;

  // reset values
  localparam logic [DATA_W-1:0] RST_RSVD_ONE   = 16'h0000;
  localparam logic [DATA_W-1:0] RST_VARIANT    = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PLL_RST    = 16'h0099;
  localparam logic [DATA_W-1:0] RST_CGEN_RST   = 16'h0009;
  localparam logic [DATA_W-1:0] RST_ANALOG_RST = 16'h0999;
  localparam logic [DATA_W-1:0] RST_PLL_PWR    = 16'h0004;
  localparam logic [DATA_W-1:0] RST_PLL_RSVD   = 16'h2113;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 16'h0000;

  // writable bits; everything else is reserved and pinned at reset value
  localparam logic [DATA_W-1:0] MASK_VARIANT    = 16'h0003;
  localparam logic [DATA_W-1:0] MASK_PLL_RST    = 16'h00ff;
  localparam logic [DATA_W-1:0] MASK_CGEN_RST   = 16'h000f;
  localparam logic [DATA_W-1:0] MASK_ANALOG_RST = 16'h0fff;
  localparam logic [DATA_W-1:0] MASK_PLL_PWR    = 16'h0007;

  // pll power control bit positions
  localparam int unsigned PLL_PWD_N_BIT  = 0;
  localparam int unsigned PLL_ENABLE_BIT = 1;
  localparam int unsigned PLL_BYPASS_BIT = 2;

  // variant field layout, soft reset field count and hold code
  localparam int unsigned VARIANT_LSB = 0;
  localparam int unsigned VARIANT_W   = 2;
  localparam int unsigned NUM_RST_FIELDS = 6;
  localparam logic [FIELD_W-1:0] SOFT_RESET_CODE = 4'h9;

  // arbitrary neutral identification value
  localparam logic [DATA_W-1:0] IDENT_DEFAULT = 16'h1234;

  // a field holds its sub-block in reset only on the exact hold code
  function automatic logic ssrp_is_hold(input logic [FIELD_W-1:0] field);
    return field == SOFT_RESET_CODE;
  endfunction

  // masked register update keeping reserved bits at their reset value
  function automatic logic [DATA_W-1:0] ssrp_merge(input logic [DATA_W-1:0] wdata,
                                                   input logic [DATA_W-1:0] mask,
                                                   input logic [DATA_W-1:0] rstv);
    return (wdata & mask) | (rstv & ~mask);
  endfunction

endpackage

// [hdl/ssrp_rst_hold.sv]
// registered decoder turning soft reset fields into sub-block hold levels
`timescale 1ns/1ps
module ssrp_rst_hold #(
  parameter int unsigned NFIELDS = ssrp_pkg::NUM_RST_FIELDS
) (
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  input  wire logic                                 ce,
  input  wire logic [NFIELDS*ssrp_pkg::FIELD_W-1:0] fields,
  output logic      [NFIELDS-1:0]                   hold
);
  import ssrp_pkg::*;

  typedef struct packed {
    logic [NFIELDS-1:0] hold;
  } ssrp_hold_state_type;

  ssrp_hold_state_type st_r;
  ssrp_hold_state_type st_nxt;

  // decode every field; held by default so sub-blocks start in reset
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NFIELDS; i++) begin
      st_nxt.hold[i] = ssrp_is_hold(fields[i*FIELD_W +: FIELD_W]);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{hold: {NFIELDS{1'b1}}};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign hold = st_r.hold;

endmodule

// [hdl/ssrp_regs.sv]
// sensor setup, soft reset and pll control register bank
//
// Summary of operation
// - A two-bit read-write variant field at address 2 holds the product variant code 0 to 3.
// - Each four-bit soft reset field holds its sub-block in reset on code 9 only, default 9.
// - Bit 0 at address 16 powers the pll up when 1 and down when 0, default 0.
// - Bit 1 at address 16 enables the pll when 1 and disables it when 0, default 0.
// - Bit 2 at address 16 bypasses the pll when 1 and uses it when 0, default 1.
`timescale 1ns/1ps
module ssrp_regs #(
  parameter logic [ssrp_pkg::DATA_W-1:0] IDENT_VALUE = ssrp_pkg::IDENT_DEFAULT
) (
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  input  wire logic                          ce,
  input  wire logic [ssrp_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [ssrp_pkg::DATA_W-1:0]   reg_wdata,
  output logic      [ssrp_pkg::DATA_W-1:0]   reg_rdata,
  output logic                               reg_rvalid,
  output logic      [ssrp_pkg::VARIANT_W-1:0] variant_code,
  output logic                               pll_rst_hold,
  output logic                               lock_det_rst_hold,
  output logic                               clkgen_rst_hold,
  output logic                               colmux_rst_hold,
  output logic                               afe_rst_hold,
  output logic                               ser_rst_hold,
  output logic                               pll_pwr_up,
  output logic                               pll_en,
  output logic                               pll_bypass
);
  import ssrp_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] variant;
    logic [DATA_W-1:0] pll_rst;
    logic [DATA_W-1:0] cgen_rst;
    logic [DATA_W-1:0] ana_rst;
    logic [DATA_W-1:0] pll_pwr;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
  } ssrp_state_type;

  localparam ssrp_state_type ST_RESET = '{
    variant:  RST_VARIANT,
    pll_rst:  RST_PLL_RST,
    cgen_rst: RST_CGEN_RST,
    ana_rst:  RST_ANALOG_RST,
    pll_pwr:  RST_PLL_PWR,
    rdata:    RDATA_UNMAPPED,
    rvalid:   1'b0
  };

  ssrp_state_type st_r;
  ssrp_state_type st_nxt;

  logic [NUM_RST_FIELDS*FIELD_W-1:0] rst_fields;
  logic [NUM_RST_FIELDS-1:0]         rst_hold;

  // positions of the sub-block hold levels in the decoder output
  localparam int unsigned HOLD_PLL    = 0;
  localparam int unsigned HOLD_LOCK   = 1;
  localparam int unsigned HOLD_CLKGEN = 2;
  localparam int unsigned HOLD_COLMUX = 3;
  localparam int unsigned HOLD_AFE    = 4;
  localparam int unsigned HOLD_SER    = 5;

  // soft reset field slots inside one word, counted from bit 0
  localparam int unsigned SLOT_LO  = 0;
  localparam int unsigned SLOT_MID = 1;
  localparam int unsigned SLOT_HI  = 2;

  // writable bits of a word; zero for read-only, pinned and unmapped words
  function automatic logic [DATA_W-1:0] wr_mask(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] m;
    m = '0;
    case (a)
      ADDR_VARIANT:    m = MASK_VARIANT;
      ADDR_PLL_RST:    m = MASK_PLL_RST;
      ADDR_CGEN_RST:   m = MASK_CGEN_RST;
      ADDR_ANALOG_RST: m = MASK_ANALOG_RST;
      ADDR_PLL_PWR:    m = MASK_PLL_PWR;
      default:         m = '0;
    endcase
    return m;
  endfunction

  // default of every word except the identification word at 0; reserved bits always come back from here
  function automatic logic [DATA_W-1:0] rst_value(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = RDATA_UNMAPPED;
    case (a)
      ADDR_RSVD_ONE:   v = RST_RSVD_ONE;
      ADDR_VARIANT:    v = RST_VARIANT;
      ADDR_PLL_RST:    v = RST_PLL_RST;
      ADDR_CGEN_RST:   v = RST_CGEN_RST;
      ADDR_ANALOG_RST: v = RST_ANALOG_RST;
      ADDR_PLL_PWR:    v = RST_PLL_PWR;
      ADDR_PLL_RSVD:   v = RST_PLL_RSVD;
      default:         v = RDATA_UNMAPPED;
    endcase
    return v;
  endfunction

  // new stored value of a written word; reserved bits fall back to default
  function automatic logic [DATA_W-1:0] write_word(input logic [ADDR_W-1:0] a,
                                                   input logic [DATA_W-1:0] d);
    return ssrp_merge(d, wr_mask(a), rst_value(a));
  endfunction

  // stored word behind an address, before reserved bits are put back
  function automatic logic [DATA_W-1:0] stored_word(input ssrp_state_type  s,
                                                    input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    case (a)
      ADDR_VARIANT:    w = s.variant;
      ADDR_PLL_RST:    w = s.pll_rst;
      ADDR_CGEN_RST:   w = s.cgen_rst;
      ADDR_ANALOG_RST: w = s.ana_rst;
      ADDR_PLL_PWR:    w = s.pll_pwr;
      default:         w = '0;
    endcase
    return w;
  endfunction

  // read value; reserved and unmapped words can only ever show their default
  function automatic logic [DATA_W-1:0] read_word(input ssrp_state_type  s,
                                                  input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    if (a == ADDR_IDENT) begin
      w = IDENT_VALUE;
    end else begin
      w = ssrp_merge(stored_word(s, a), wr_mask(a), rst_value(a));
    end
    return w;
  endfunction

  // one four-bit soft reset field of a word
  function automatic logic [FIELD_W-1:0] field_of(input logic [DATA_W-1:0] w,
                                                  input int unsigned       k);
    return w[k*FIELD_W +: FIELD_W];
  endfunction

  // writes and reads; a write to a read-only or unmapped address is dropped
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_VARIANT: begin
          st_nxt.variant = write_word(reg_addr, reg_wdata);
        end
        ADDR_PLL_RST: begin
          st_nxt.pll_rst = write_word(reg_addr, reg_wdata);
        end
        ADDR_CGEN_RST: begin
          st_nxt.cgen_rst = write_word(reg_addr, reg_wdata);
        end
        ADDR_ANALOG_RST: begin
          st_nxt.ana_rst = write_word(reg_addr, reg_wdata);
        end
        ADDR_PLL_PWR: begin
          st_nxt.pll_pwr = write_word(reg_addr, reg_wdata);
        end
        default: begin
          // reserved word at 0x11 is pinned: writes cannot disturb it
          st_nxt.rdata = st_r.rdata;
        end
      endcase
    end
    // read data is captured before any same-cycle write lands
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = read_word(st_r, reg_addr);
    end
  end

  // all state frozen while ce is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // field order: pll, lock detector, clock gen, column mux, afe, serializer
  assign rst_fields = {field_of(st_r.ana_rst, SLOT_HI),
                       field_of(st_r.ana_rst, SLOT_MID),
                       field_of(st_r.ana_rst, SLOT_LO),
                       field_of(st_r.cgen_rst, SLOT_LO),
                       field_of(st_r.pll_rst, SLOT_MID),
                       field_of(st_r.pll_rst, SLOT_LO)};

  // hold levels re-registered so each output leaves a flop; one extra cycle
  ssrp_rst_hold #(
    .NFIELDS(NUM_RST_FIELDS)
  ) u_rst_hold (
    .sys_clk(sys_clk),
    .nrst   (nrst),
    .ce     (ce),
    .fields (rst_fields),
    .hold   (rst_hold)
  );

  // register outputs
  assign reg_rdata         = st_r.rdata;
  assign reg_rvalid        = st_r.rvalid;
  assign variant_code      = st_r.variant[VARIANT_LSB +: VARIANT_W];
  assign pll_rst_hold      = rst_hold[HOLD_PLL];
  assign lock_det_rst_hold = rst_hold[HOLD_LOCK];
  assign clkgen_rst_hold   = rst_hold[HOLD_CLKGEN];
  assign colmux_rst_hold   = rst_hold[HOLD_COLMUX];
  assign afe_rst_hold      = rst_hold[HOLD_AFE];
  assign ser_rst_hold      = rst_hold[HOLD_SER];
  assign pll_pwr_up        = st_r.pll_pwr[PLL_PWD_N_BIT];
  assign pll_en            = st_r.pll_pwr[PLL_ENABLE_BIT];
  assign pll_bypass        = st_r.pll_pwr[PLL_BYPASS_BIT];

endmodule

// [sim/ssrp_regs_asserts.sv]
// port assertions for the setup, reset and pll register bank
`timescale 1ns/1ps
module ssrp_regs_chk (
  input wire logic                        sys_clk,
  input wire logic                        nrst,
  input wire logic                        ce,
  input wire logic [ssrp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic                        reg_wr,
  input wire logic                        reg_rd,
  input wire logic [ssrp_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [ssrp_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                        reg_rvalid,
  input wire logic [1:0]                  variant_code,
  input wire logic                        pll_rst_hold,
  input wire logic                        pll_pwr_up,
  input wire logic                        pll_en,
  input wire logic                        pll_bypass
);
  import ssrp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // write taken at this edge; ce low freezes everything
  logic wr_ok;
  assign wr_ok = ce && reg_wr;
  variant_write_a: assert property (
    wr_ok && reg_addr == ADDR_VARIANT |=> variant_code == $past(reg_wdata[VARIANT_W-1:0]))
    else $error("variant code not updated");
  pll_hold_a: assert property (
    wr_ok && reg_addr == ADDR_PLL_RST ##1 ce
      |=> pll_rst_hold == ($past(reg_wdata[FIELD_W-1:0], 2) == SOFT_RESET_CODE))
    else $error("pll hold level wrong");
  pll_power_a: assert property (
    wr_ok && reg_addr == ADDR_PLL_PWR |=> pll_pwr_up == $past(reg_wdata[0]))
    else $error("pll power bit wrong");
  pll_enable_a: assert property (
    wr_ok && reg_addr == ADDR_PLL_PWR |=> pll_en == $past(reg_wdata[1]))
    else $error("pll enable bit wrong");
  pll_bypass_a: assert property (
    wr_ok && reg_addr == ADDR_PLL_PWR |=> pll_bypass == $past(reg_wdata[2]))
    else $error("pll bypass bit wrong");
  rsvd_read_a: assert property (
    ce && reg_rd && reg_addr == ADDR_PLL_RSVD |=> reg_rvalid && reg_rdata == RST_PLL_RSVD)
    else $error("reserved word changed");
  cover property (wr_ok && reg_addr == ADDR_PLL_PWR);
  cover property (reg_rvalid && reg_rdata == RST_PLL_RSVD);
  cover property ($fell(pll_rst_hold));
endmodule
bind ssrp_regs ssrp_regs_chk u_chk (.sys_clk, .nrst, .ce, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .reg_rvalid, .variant_code, .pll_rst_hold, .pll_pwr_up, .pll_en,
  .pll_bypass);

// [sim/ssrp_host.sv]
// host controller model issuing register writes and reads
`timescale 1ns/1ps
module ssrp_host (
  input  wire logic                        sys_clk,
  output logic      [ssrp_pkg::ADDR_W-1:0] reg_addr,
  output logic                             reg_wr,
  output logic                             reg_rd,
  output logic      [ssrp_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic [ssrp_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        reg_rvalid
);
  import ssrp_pkg::*;
  // idle port at time zero
  initial begin
    reg_addr = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = '0;
  end
  // one write: strobe held across exactly one taking edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // one read: answer lands on the taking edge, picked up once settled
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q, output logic v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// [sim/tb_sensor_setup_reset_pll_regs.sv]
// self-checking bench for the setup, reset and pll register bank
`timescale 1ns/1ps
module tb_sensor_setup_reset_pll_regs;
  import ssrp_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, reg_rvalid, pll_pwr_up, pll_en, pll_bypass;
  logic [1:0] variant_code;
  logic [DATA_W-1:0] q_frz;
  logic v_frz;
  logic [5:0] hold;
  int mismatches = 0;
  int cmp_count = 0;
  // last entry is an unmapped address
  localparam logic [ADDR_W-1:0] ADDRS [9] = '{9'h000, 9'h001, 9'h002, 9'h008, 9'h009,
    9'h00a, 9'h010, 9'h011, 9'h003};
  localparam logic [DATA_W-1:0] RSTV [9] = '{IDENT_DEFAULT, 16'h0000, 16'h0000, 16'h0099,
    16'h0009, 16'h0999, 16'h0004, 16'h2113, 16'h0000};
  localparam logic [DATA_W-1:0] ONES [9] = '{IDENT_DEFAULT, 16'h0000, 16'h0003, 16'h00ff,
    16'h000f, 16'h0fff, 16'h0007, 16'h2113, 16'h0000};
  always #10 sys_clk = ~sys_clk;
  ssrp_regs dut (.sys_clk, .nrst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .variant_code, .pll_rst_hold(hold[0]), .lock_det_rst_hold(hold[1]),
    .clkgen_rst_hold(hold[2]), .colmux_rst_hold(hold[3]), .afe_rst_hold(hold[4]),
    .ser_rst_hold(hold[5]), .pll_pwr_up, .pll_en, .pll_bypass);
  ssrp_host host (.sys_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid);
  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] q;
    logic v;
    host.rd(a, q, v);
    chk("read valid", 16'h0001, {15'h0000, v});
    chk("read data", e, q);
  endtask
  // hold levels trail a write by one edge more than the other outputs
  task automatic ochk(input logic [1:0] vc, input logic [5:0] h, input logic [2:0] p);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("variant", {14'h0000, vc}, {14'h0000, variant_code});
    chk("holds", {10'h000, h}, {10'h000, hold});
    chk("pll bits", {13'h0000, p}, {13'h0000, pll_bypass, pll_en, pll_pwr_up});
  endtask
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    ochk(2'h0, 6'h3f, 3'h4);
    foreach (ADDRS[i]) rchk(ADDRS[i], RSTV[i]);
    foreach (ADDRS[i]) host.wr(ADDRS[i], 16'hffff);
    ochk(2'h3, 6'h00, 3'h7);
    foreach (ADDRS[i]) rchk(ADDRS[i], ONES[i]);
    for (int c = 0; c < 4; c++) begin
      host.wr(ADDR_VARIANT, {14'h0000, 2'(c)});
      ochk(2'(c), 6'h00, 3'h7);
    end
    host.wr(ADDR_PLL_RST, 16'h0098);
    host.wr(ADDR_CGEN_RST, 16'h0009);
    host.wr(ADDR_ANALOG_RST, 16'h0989);
    for (int b = 0; b < 3; b++) begin
      host.wr(ADDR_PLL_PWR, 16'h0001 << b);
      ochk(2'h3, 6'h2e, 3'h1 << b);
    end
    // clock enable low: neither a read nor a write may be taken
    @(posedge sys_clk);
    ce <= 1'b0;
    host.rd(ADDR_VARIANT, q_frz, v_frz);
    host.wr(ADDR_VARIANT, 16'h0000);
    ce <= 1'b1;
    chk("read while frozen", 16'h0000, {15'h0000, v_frz});
    ochk(2'h3, 6'h2e, 3'h4);
    // second reset in mid-run, applied on an edge and held across one edge
    @(posedge sys_clk);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    ochk(2'h0, 6'h3f, 3'h4);
    end_of_test();
  end
  // bounded run in case the port stops answering
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
endmodule
